// ---- core/sec_pkg.sv ----
// Package with constants shared by the SRAM error-correcting controller
package sec_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DBG_PTR = 8'h08;
  localparam logic [7:0] OFS_DBG_DATA = 8'h0c;
  localparam logic [7:0] OFS_DBG_CHECK = 8'h10;
  localparam logic [7:0] OFS_DBG_CMD = 8'h14;

  // Field positions
  localparam int BIT_SBE_IRQ_EN = 0;
  localparam int BIT_SBE_FLAG = 0;
  localparam int BIT_READY = 1;
  localparam int BIT_REPAIR_DIS = 7;
  localparam int BIT_DBG_WRITE = 1;
  localparam int BIT_DBG_READ = 0;

  // Values after reset
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_REPAIR_DIS = 1'b0;
  localparam logic [15:0] RST_DBG_PTR = 16'h0000;
  localparam logic [15:0] RST_DBG_DATA = 16'h0000;
  localparam logic [5:0] RST_DBG_CHECK = 6'h00;
  localparam logic [31:0] RST_WB_DATA = 32'h0000_0000;

  // Check bit masks over the 16-bit data word
  localparam logic [15:0] CHK_MASK0 = 16'h443f;
  localparam logic [15:0] CHK_MASK1 = 16'h13c7;
  localparam logic [15:0] CHK_MASK2 = 16'he1d1;
  localparam logic [15:0] CHK_MASK3 = 16'hee60;
  localparam logic [15:0] CHK_MASK4 = 16'h3e8a;
  localparam logic [15:0] CHK_MASK5 = 16'h993c;

  // Cycles the read path stalls after a repairing read
  localparam int REPAIR_STALL_CYCLES = 1;

  // Controller states, Gray coded along init, idle, merge, stall
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_RMW = 2'b11,
    ST_HOLD = 2'b10
  } sec_state_t;

endpackage

// ---- core/sec_ctrl.sv ----
// SRAM error-correcting controller with built-in array, debug path and registers
//
// Summary of operation
// - Stall next read one cycle after repair.
// - Single-error interrupt only when enable set.
// - Double errors go out to chip logic.
// - Aligned 2/4 byte write: encode, store directly.
// - Other writes: read, check, merge, rewrite.
// - Merge into corrected data, set single flag.
// - Double error in merge: block write, report.
// - Reads check, correct, and write back.
// - Repair disable: correct data, flag, no write-back.
// - Single error on read sets flag.
// - Double error read returns data marked invalid.
// - Zero-fill at reset; ready bit gates access.
// - Check bits 0..2 from masks, inverted parity.
// - Check bits 3..5 from masks, inverted parity.
// - Debug access waits for normal accesses.
// - Debug request during fill waits for fill.
// - Command bits ignored while debug access busy.
// - Debug write stores raw data and check.
// - Debug read loads raw word, no repair.
// - Both command bits: only the write runs.
// - Bit 7 repair disable; zeros in command bits 1, 0 ignored.
// - Command writes only in special mode.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ns
module sec_ctrl #(
  parameter int AW = 11
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Wishbone register slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // System memory port from the bus initiators
  input wire logic MEM_REQ_I,
  input wire logic MEM_WE_I,
  input wire logic [AW-1:0] MEM_ADDR_I,
  input wire logic [3:0] MEM_BE_I,
  input wire logic [31:0] MEM_WDATA_I,
  output logic MEM_ACK_O,
  output logic [31:0] MEM_RDATA_O,
  output logic MEM_INVALID_O,
  output logic MEM_WERR_O,
  // Chip-level signals
  input wire logic SPECIAL_MODE_I,
  output logic READY_O,
  output logic IRQ_SBE_O,
  output logic DBL_ERR_O
);

  localparam int WORDS = 2 ** AW;

  sec_pkg::sec_state_t state_q;
  logic [AW-1:0] init_cnt_q;
  logic ready_q;
  logic mem_ack_q;
  logic [31:0] rdata_q;
  logic invalid_q;
  logic werr_q;
  logic dbl_q;
  logic sbe_flag_q;
  logic irq_en_q;
  logic repair_dis_q;
  logic cmd_wr_q;
  logic cmd_rd_q;
  logic [15:0] dbg_ptr_q;
  logic [15:0] dbg_data_q;
  logic [5:0] dbg_check_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  logic spec_s1_q;
  logic spec_s2_q;
  logic spec_s3_q;
  logic special_q;

  logic [21:0] mem_lo [WORDS];
  logic [21:0] mem_hi [WORDS];

  // Inverted parity of masked data per check bit
  function automatic logic [5:0] enc(input logic [15:0] d);
    enc[0] = ~(^(d & sec_pkg::CHK_MASK0));
    enc[1] = ~(^(d & sec_pkg::CHK_MASK1));
    enc[2] = ~(^(d & sec_pkg::CHK_MASK2));
    enc[3] = ~(^(d & sec_pkg::CHK_MASK3));
    enc[4] = ~(^(d & sec_pkg::CHK_MASK4));
    enc[5] = ~(^(d & sec_pkg::CHK_MASK5));
  endfunction

  // Returns {double, single, corrected data} for a stored {check, data} entry
  function automatic logic [17:0] dec(input logic [21:0] w);
    logic [5:0] syn;
    logic [5:0] col;
    logic [15:0] d;
    logic sgl;
    logic dbl;
    d = w[15:0];
    syn = w[21:16] ^ enc(w[15:0]);
    sgl = 1'b0;
    dbl = 1'b0;
    if (syn != 6'h00) begin
      dbl = 1'b1;
      for (int i = 0; i < 16; i++) begin
        col = {sec_pkg::CHK_MASK5[i], sec_pkg::CHK_MASK4[i], sec_pkg::CHK_MASK3[i],
               sec_pkg::CHK_MASK2[i], sec_pkg::CHK_MASK1[i], sec_pkg::CHK_MASK0[i]};
        if (syn == col) begin
          d[i] = ~d[i];
          sgl = 1'b1;
          dbl = 1'b0;
        end
      end
      // A flipped check bit leaves the data intact
      if ($onehot(syn)) begin
        sgl = 1'b1;
        dbl = 1'b0;
      end
    end
    dec = {dbl, sgl, d};
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] nd, input logic [3:0] sel);
    wr16 = old;
    if (sel[0]) begin
      wr16[7:0] = nd[7:0];
    end
    if (sel[1]) begin
      wr16[15:8] = nd[15:8];
    end
  endfunction

  // Read side decode of both halves
  logic [AW-1:0] rd_idx;
  logic [AW-1:0] dbg_idx;
  logic [21:0] raw_lo;
  logic [21:0] raw_hi;
  logic [17:0] dl;
  logic [17:0] dh;
  logic be_lo;
  logic be_hi;
  logic aligned;
  logic acc_go;
  logic dbg_go;
  logic [15:0] m_lo;
  logic [15:0] m_hi;
  logic rmw_dbl;
  logic rmw_sgl;
  logic rd_sgl;
  logic rd_dbl;
  logic repair;

  assign dbg_idx = dbg_ptr_q[AW:1];
  assign rd_idx = MEM_REQ_I ? MEM_ADDR_I : dbg_idx;
  assign raw_lo = mem_lo[rd_idx];
  assign raw_hi = mem_hi[rd_idx];
  assign dl = dec(raw_lo);
  assign dh = dec(raw_hi);
  assign be_lo = |MEM_BE_I[1:0];
  assign be_hi = |MEM_BE_I[3:2];
  assign aligned = (MEM_BE_I == 4'hf) || (MEM_BE_I == 4'h3) || (MEM_BE_I == 4'hc);
  assign acc_go = (state_q == sec_pkg::ST_IDLE) && MEM_REQ_I && !mem_ack_q;
  // Debug runs only when no normal access is pending or finishing
  assign dbg_go = (state_q == sec_pkg::ST_IDLE) && !MEM_REQ_I && !mem_ack_q && (cmd_wr_q || cmd_rd_q);

  // New bytes over corrected old data
  assign m_lo = {MEM_BE_I[1] ? MEM_WDATA_I[15:8] : dl[15:8], MEM_BE_I[0] ? MEM_WDATA_I[7:0] : dl[7:0]};
  assign m_hi = {MEM_BE_I[3] ? MEM_WDATA_I[31:24] : dh[15:8], MEM_BE_I[2] ? MEM_WDATA_I[23:16] : dh[7:0]};
  assign rmw_dbl = (be_lo && dl[17]) || (be_hi && dh[17]);
  assign rmw_sgl = (be_lo && dl[16]) || (be_hi && dh[16]);
  assign rd_sgl = dl[16] || dh[16];
  assign rd_dbl = dl[17] || dh[17];
  assign repair = acc_go && !MEM_WE_I && rd_sgl && !rd_dbl && !repair_dis_q;

  // Array write selection
  logic [AW-1:0] wr_idx;
  logic wr_lo;
  logic wr_hi;
  logic [21:0] val_lo;
  logic [21:0] val_hi;

  always_comb begin
    wr_idx = MEM_ADDR_I;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    val_lo = 22'h000000;
    val_hi = 22'h000000;
    unique case (state_q)
      sec_pkg::ST_INIT: begin
        wr_idx = init_cnt_q;
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        val_lo = {enc(16'h0000), 16'h0000};
        val_hi = {enc(16'h0000), 16'h0000};
      end
      sec_pkg::ST_IDLE: begin
        if (acc_go) begin
          if (MEM_WE_I && aligned) begin
            wr_lo = be_lo;
            wr_hi = be_hi;
            val_lo = {enc(MEM_WDATA_I[15:0]), MEM_WDATA_I[15:0]};
            val_hi = {enc(MEM_WDATA_I[31:16]), MEM_WDATA_I[31:16]};
          end else if (repair) begin
            wr_lo = dl[16] && !dl[17];
            wr_hi = dh[16] && !dh[17];
            val_lo = {enc(dl[15:0]), dl[15:0]};
            val_hi = {enc(dh[15:0]), dh[15:0]};
          end
        end else if (dbg_go && cmd_wr_q) begin
          wr_idx = dbg_idx;
          wr_lo = !dbg_ptr_q[0];
          wr_hi = dbg_ptr_q[0];
          val_lo = {dbg_check_q, dbg_data_q};
          val_hi = {dbg_check_q, dbg_data_q};
        end
      end
      sec_pkg::ST_RMW: begin
        if (!rmw_dbl) begin
          wr_lo = be_lo;
          wr_hi = be_hi;
          val_lo = {enc(m_lo), m_lo};
          val_hi = {enc(m_hi), m_hi};
        end
      end
      sec_pkg::ST_HOLD: begin
        wr_lo = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (wr_lo) begin
      mem_lo[wr_idx] <= val_lo;
    end
    if (wr_hi) begin
      mem_hi[wr_idx] <= val_hi;
    end
  end

  // Controller sequence and fill counter
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_q <= sec_pkg::ST_INIT;
      init_cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      unique case (state_q)
        sec_pkg::ST_INIT: begin
          init_cnt_q <= init_cnt_q + 1'b1;
          if (init_cnt_q == AW'(WORDS - 1)) begin
            state_q <= sec_pkg::ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        sec_pkg::ST_IDLE: begin
          if (acc_go && MEM_WE_I && !aligned) begin
            state_q <= sec_pkg::ST_RMW;
          end else if (repair) begin
            state_q <= sec_pkg::ST_HOLD;
          end
        end
        sec_pkg::ST_RMW: begin
          state_q <= sec_pkg::ST_IDLE;
        end
        sec_pkg::ST_HOLD: begin
          state_q <= sec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Initiator answer
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mem_ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      invalid_q <= 1'b0;
      werr_q <= 1'b0;
      dbl_q <= 1'b0;
    end else begin
      mem_ack_q <= 1'b0;
      dbl_q <= 1'b0;
      if (acc_go && !(MEM_WE_I && !aligned)) begin
        mem_ack_q <= 1'b1;
        werr_q <= 1'b0;
        invalid_q <= 1'b0;
        if (!MEM_WE_I) begin
          rdata_q <= {dh[15:0], dl[15:0]};
          invalid_q <= rd_dbl;
          dbl_q <= rd_dbl;
        end
      end else if (state_q == sec_pkg::ST_RMW) begin
        mem_ack_q <= 1'b1;
        invalid_q <= 1'b0;
        werr_q <= rmw_dbl;
        dbl_q <= rmw_dbl;
      end
    end
  end

  // Sticky single-error flag; set beats a software clear
  logic sbe_set;
  logic sbe_clr;
  logic wb_take;
  logic wb_wr;

  assign wb_take = WB_CYC_I && WB_STB_I && !wb_ack_q;
  // Writes land on the edge where the master samples ack
  assign wb_wr = WB_CYC_I && WB_STB_I && WB_WE_I && wb_ack_q;
  assign sbe_set = (acc_go && !MEM_WE_I && rd_sgl) || (state_q == sec_pkg::ST_RMW && !rmw_dbl && rmw_sgl);
  assign sbe_clr = wb_wr && WB_ADR_I == sec_pkg::OFS_STATUS && WB_SEL_I[0] && WB_DAT_I[sec_pkg::BIT_SBE_FLAG];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sbe_flag_q <= 1'b0;
    end else if (sbe_set) begin
      sbe_flag_q <= 1'b1;
    end else if (sbe_clr) begin
      sbe_flag_q <= 1'b0;
    end
  end

  // Special mode pin: three stages, accepted when the last two agree
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      spec_s1_q <= 1'b0;
      spec_s2_q <= 1'b0;
      spec_s3_q <= 1'b0;
      special_q <= 1'b0;
    end else begin
      spec_s1_q <= SPECIAL_MODE_I;
      spec_s2_q <= spec_s1_q;
      spec_s3_q <= spec_s2_q;
      if (spec_s2_q == spec_s3_q) begin
        special_q <= spec_s3_q;
      end
    end
  end

  // Debug command register
  logic cmd_wr_en;
  logic dbg_busy;

  assign dbg_busy = cmd_wr_q || cmd_rd_q;
  assign cmd_wr_en = wb_wr && WB_ADR_I == sec_pkg::OFS_DBG_CMD && WB_SEL_I[0] && special_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      repair_dis_q <= sec_pkg::RST_REPAIR_DIS;
      cmd_wr_q <= 1'b0;
      cmd_rd_q <= 1'b0;
    end else begin
      if (cmd_wr_en) begin
        repair_dis_q <= WB_DAT_I[sec_pkg::BIT_REPAIR_DIS];
      end
      if (dbg_go) begin
        cmd_wr_q <= 1'b0;
        cmd_rd_q <= 1'b0;
      end else if (cmd_wr_en && !dbg_busy) begin
        // Ones start a command, zeros leave it
        if (WB_DAT_I[sec_pkg::BIT_DBG_WRITE]) begin
          cmd_wr_q <= 1'b1;
        end else if (WB_DAT_I[sec_pkg::BIT_DBG_READ]) begin
          cmd_rd_q <= 1'b1;
        end
      end
    end
  end

  // Debug pointer, data and check registers
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      dbg_ptr_q <= sec_pkg::RST_DBG_PTR;
      dbg_data_q <= sec_pkg::RST_DBG_DATA;
      dbg_check_q <= sec_pkg::RST_DBG_CHECK;
    end else begin
      if (wb_wr && WB_ADR_I == sec_pkg::OFS_DBG_PTR) begin
        dbg_ptr_q <= wr16(dbg_ptr_q, WB_DAT_I, WB_SEL_I);
      end
      if (dbg_go && !cmd_wr_q) begin
        // Raw word and stored check, no correction
        dbg_data_q <= dbg_ptr_q[0] ? raw_hi[15:0] : raw_lo[15:0];
        dbg_check_q <= dbg_ptr_q[0] ? raw_hi[21:16] : raw_lo[21:16];
      end else begin
        if (wb_wr && WB_ADR_I == sec_pkg::OFS_DBG_DATA) begin
          dbg_data_q <= wr16(dbg_data_q, WB_DAT_I, WB_SEL_I);
        end
        if (wb_wr && WB_ADR_I == sec_pkg::OFS_DBG_CHECK && WB_SEL_I[0]) begin
          dbg_check_q <= WB_DAT_I[5:0];
        end
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      irq_en_q <= sec_pkg::RST_IRQ_EN;
    end else if (wb_wr && WB_ADR_I == sec_pkg::OFS_IRQ_EN && WB_SEL_I[0]) begin
      irq_en_q <= WB_DAT_I[sec_pkg::BIT_SBE_IRQ_EN];
    end
  end

  // Wishbone acknowledge and read data
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (WB_ADR_I)
      sec_pkg::OFS_IRQ_EN: rd_mux[sec_pkg::BIT_SBE_IRQ_EN] = irq_en_q;
      sec_pkg::OFS_STATUS: begin
        rd_mux[sec_pkg::BIT_SBE_FLAG] = sbe_flag_q;
        rd_mux[sec_pkg::BIT_READY] = ready_q;
      end
      sec_pkg::OFS_DBG_PTR: rd_mux[15:0] = dbg_ptr_q;
      sec_pkg::OFS_DBG_DATA: rd_mux[15:0] = dbg_data_q;
      sec_pkg::OFS_DBG_CHECK: rd_mux[5:0] = dbg_check_q;
      sec_pkg::OFS_DBG_CMD: begin
        rd_mux[sec_pkg::BIT_REPAIR_DIS] = repair_dis_q;
        rd_mux[sec_pkg::BIT_DBG_WRITE] = cmd_wr_q;
        rd_mux[sec_pkg::BIT_DBG_READ] = cmd_rd_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= sec_pkg::RST_WB_DATA;
    end else begin
      wb_ack_q <= wb_take;
      if (wb_take && !WB_WE_I) begin
        wb_dat_q <= rd_mux;
      end
    end
  end

  assign WB_ACK_O = wb_ack_q;
  assign WB_DAT_O = wb_dat_q;
  assign MEM_ACK_O = mem_ack_q;
  assign MEM_RDATA_O = rdata_q;
  assign MEM_INVALID_O = invalid_q;
  assign MEM_WERR_O = werr_q;
  assign READY_O = ready_q;
  assign IRQ_SBE_O = sbe_flag_q && irq_en_q;
  assign DBL_ERR_O = dbl_q;

endmodule

// ---- tb/sec_ctrl_checker.sv ----
// Port assertions for the SRAM error-correcting controller
`timescale 1ns/1ns
module sec_ctrl_checker #(
  parameter int AW = 11
) (
  // Watched ports
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic MEM_REQ_I,
  input wire logic MEM_WE_I,
  input wire logic [3:0] MEM_BE_I,
  input wire logic MEM_ACK_O,
  input wire logic MEM_INVALID_O,
  input wire logic MEM_WERR_O,
  input wire logic READY_O,
  input wire logic IRQ_SBE_O,
  input wire logic DBL_ERR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic algn;
  logic wbw;
  assign algn = MEM_BE_I == 4'hf || MEM_BE_I == 4'h3 || MEM_BE_I == 4'hc;
  assign wbw = WB_CYC_I && WB_STB_I && WB_WE_I;
  fill_gate_a: assert property (!READY_O |-> !MEM_ACK_O) else $error("ack while filling");
  ready_hold_a: assert property (READY_O |=> READY_O) else $error("ready dropped");
  aligned_write_a: assert property ($rose(MEM_REQ_I) && MEM_WE_I && algn && READY_O
    |=> MEM_ACK_O && !MEM_WERR_O) else $error("aligned write not single cycle");
  merge_write_a: assert property ($rose(MEM_REQ_I) && MEM_WE_I && !algn && READY_O
    |=> !MEM_ACK_O ##1 MEM_ACK_O) else $error("merge write not two cycles");
  read_lat_a: assert property ($rose(MEM_REQ_I) && !MEM_WE_I && READY_O |=> MEM_ACK_O)
    else $error("read not single cycle");
  blocked_write_a: assert property (MEM_ACK_O && MEM_WERR_O |-> MEM_WE_I && !algn && DBL_ERR_O)
    else $error("write error outside merge");
  invalid_read_a: assert property (MEM_ACK_O && MEM_INVALID_O |-> !MEM_WE_I && DBL_ERR_O)
    else $error("invalid mark without double error");
  double_out_a: assert property (DBL_ERR_O |-> MEM_ACK_O && (MEM_INVALID_O || MEM_WERR_O))
    else $error("double error pulse misplaced");
  irq_sticky_a: assert property (IRQ_SBE_O && !wbw |=> IRQ_SBE_O) else $error("irq dropped alone");
endmodule
bind sec_ctrl sec_ctrl_checker #(.AW(AW)) u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .MEM_REQ_I(MEM_REQ_I), .MEM_WE_I(MEM_WE_I), .MEM_BE_I(MEM_BE_I),
  .MEM_ACK_O(MEM_ACK_O), .MEM_INVALID_O(MEM_INVALID_O), .MEM_WERR_O(MEM_WERR_O), .READY_O(READY_O),
  .IRQ_SBE_O(IRQ_SBE_O), .DBL_ERR_O(DBL_ERR_O));

// ---- tb/sec_mem_initiator.sv ----
// Bus initiator model on the memory port
`timescale 1ns/1ns
module sec_mem_initiator #(
  parameter int AW = 11
) (
  // Clock, reset and command from the bench
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  // Memory port
  input wire logic ack_i,
  output logic req_o,
  output logic we_o,
  output logic [AW-1:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o,
  output logic done_o
);
  logic [1:0] gap_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
      we_o <= 1'b0;
      addr_o <= '0;
      be_o <= 4'h0;
      wdata_o <= 32'h0;
      done_o <= 1'b0;
      gap_q <= 2'h0;
    end else begin
      done_o <= 1'b0;
      if (req_o && ack_i) begin
        // Released lines show the inverse so stale values never pass
        req_o <= 1'b0;
        done_o <= 1'b1;
        gap_q <= 2'h2;
        we_o <= ~we_o;
        addr_o <= ~addr_o;
        be_o <= ~be_o;
        wdata_o <= ~wdata_o;
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end else if (go_i && !req_o) begin
        req_o <= 1'b1;
        we_o <= we_i;
        addr_o <= addr_i;
        be_o <= be_i;
        wdata_o <= wdata_i;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the SRAM error-correcting controller
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, cyc, stb, wb_we, spec, go, op_we, ack, req, m_we, done, inv, werr, ready, irq, dbl, wback;
  logic [7:0] adr;
  logic [3:0] sel, op_be, m_be, op_adr, m_adr;
  logic [31:0] wdat, op_wd, m_wd, rdata, wbq, q;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  sec_ctrl #(.AW(4)) dut (.CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wb_we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(wbq), .WB_ACK_O(wback), .MEM_REQ_I(req),
    .MEM_WE_I(m_we), .MEM_ADDR_I(m_adr), .MEM_BE_I(m_be), .MEM_WDATA_I(m_wd), .MEM_ACK_O(ack),
    .MEM_RDATA_O(rdata), .MEM_INVALID_O(inv), .MEM_WERR_O(werr), .SPECIAL_MODE_I(spec), .READY_O(ready),
    .IRQ_SBE_O(irq), .DBL_ERR_O(dbl));
  sec_mem_initiator #(.AW(4)) u_ini (.clk_i(clk), .rst_i(rst), .go_i(go), .we_i(op_we), .addr_i(op_adr),
    .be_i(op_be), .wdata_i(op_wd), .ack_i(ack), .req_o(req), .we_o(m_we), .addr_o(m_adr), .be_o(m_be),
    .wdata_o(m_wd), .done_o(done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [5:0] ecc(input logic [15:0] d);
    ecc = ~{^(d & 16'h993c), ^(d & 16'h3e8a), ^(d & 16'hee60), ^(d & 16'he1d1), ^(d & 16'h13c7), ^(d & 16'h443f)};
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    wb_we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wback !== 1'b1);
    q = wbq;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mem(input logic w, input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
    go <= 1'b1;
    op_we <= w;
    op_adr <= a;
    op_be <= b;
    op_wd <= d;
    do @(posedge clk); while (done !== 1'b1);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic dbg(input logic [7:0] cmd, input logic [15:0] p, input logic [15:0] d, input logic [5:0] c);
    wb(1'b1, sec_pkg::OFS_DBG_PTR, {16'h0000, p});
    wb(1'b1, sec_pkg::OFS_DBG_DATA, {16'h0000, d});
    wb(1'b1, sec_pkg::OFS_DBG_CHECK, {26'h0, c});
    wb(1'b1, sec_pkg::OFS_DBG_CMD, {24'h0, cmd});
    do wb(1'b0, sec_pkg::OFS_DBG_CMD, 32'h0); while (q[1:0] !== 2'b00);
  endtask
  task automatic dread(input logic [7:0] cmd, input logic [15:0] p, input logic [15:0] d, input logic [5:0] c);
    dbg(cmd, p, 16'h0000, 6'h00);
    wb(1'b0, sec_pkg::OFS_DBG_DATA, 32'h0);
    chk("raw data", {16'h0000, d}, q);
    wb(1'b0, sec_pkg::OFS_DBG_CHECK, 32'h0);
    chk("raw check", {26'h0, c}, q);
  endtask
  task automatic flag(input logic e);
    wb(1'b0, sec_pkg::OFS_STATUS, 32'h0);
    chk("error flag", 32'(e), 32'(q[sec_pkg::BIT_SBE_FLAG]));
  endtask
  always @(posedge clk) begin
    cycles++;
    // Whole sequence needs well under a thousand cycles
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    {rst, spec, sel} <= {2'b10, 4'hf};
    {cyc, stb, wb_we, adr, wdat} <= '0;
    {go, op_we, op_adr, op_be, op_wd} <= '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, sec_pkg::OFS_STATUS, 32'h0);
    chk("ready bit", 32'h0, 32'(q[sec_pkg::BIT_READY]));
    mem(1'b0, 4'h5, 4'hf, 32'h0);
    chk("filled word", 32'h0, rdata);
    chk("ready pin", 32'h1, 32'(ready));
    wb(1'b1, sec_pkg::OFS_DBG_CMD, 32'h81);
    wb(1'b0, sec_pkg::OFS_DBG_CMD, 32'h0);
    chk("command reg", 32'h0, q);
    $display("end of test: fill and mode");
    spec <= 1'b1;
    repeat (6) @(posedge clk);
    mem(1'b1, 4'h3, 4'hf, 32'h12345678);
    dread(8'h01, 16'h0006, 16'h5678, ecc(16'h5678));
    dread(8'h01, 16'h0007, 16'h1234, ecc(16'h1234));
    mem(1'b1, 4'h3, 4'h2, 32'h0000ab00);
    mem(1'b0, 4'h3, 4'hf, 32'h0);
    chk("merged word", 32'h1234ab78, rdata);
    mem(1'b1, 4'h9, 4'hc, 32'h9abc0000);
    mem(1'b1, 4'h9, 4'h6, 32'h00def000);
    mem(1'b0, 4'h9, 4'hf, 32'h0);
    chk("two-half merge", 32'h9adef000, rdata);
    $display("end of test: writes");
    wb(1'b1, sec_pkg::OFS_IRQ_EN, 32'h1);
    dbg(8'h02, 16'h0006, 16'haa78, ecc(16'hab78));
    mem(1'b0, 4'h3, 4'hf, 32'h0);
    chk("corrected word", 32'h1234ab78, rdata);
    chk("irq pin", 32'h1, 32'(irq));
    dread(8'h01, 16'h0006, 16'hab78, ecc(16'hab78));
    flag(1'b1);
    wb(1'b1, sec_pkg::OFS_IRQ_EN, 32'h0);
    chk("masked irq", 32'h0, 32'(irq));
    wb(1'b1, sec_pkg::OFS_STATUS, 32'h1);
    flag(1'b0);
    $display("end of test: repair");
    wb(1'b1, sec_pkg::OFS_DBG_CMD, 32'h80);
    dbg(8'h82, 16'h0006, 16'haa78, ecc(16'hab78));
    chk("repair disable bit", 32'h80, q);
    mem(1'b0, 4'h3, 4'hf, 32'h0);
    chk("corrected word", 32'h1234ab78, rdata);
    flag(1'b1);
    dread(8'h81, 16'h0006, 16'haa78, ecc(16'hab78));
    wb(1'b1, sec_pkg::OFS_DBG_CMD, 32'h0);
    wb(1'b1, sec_pkg::OFS_STATUS, 32'h1);
    mem(1'b1, 4'h3, 4'h1, 32'h000000cd);
    chk("merge error", 32'h0, 32'(werr));
    flag(1'b1);
    dread(8'h01, 16'h0006, 16'habcd, ecc(16'habcd));
    wb(1'b1, sec_pkg::OFS_STATUS, 32'h1);
    $display("end of test: single errors");
    dbg(8'h02, 16'h0006, 16'habce, ecc(16'habcd));
    mem(1'b0, 4'h3, 4'hf, 32'h0);
    chk("invalid mark", 32'h1, 32'(inv));
    chk("raw word", 32'h1234abce, rdata);
    mem(1'b1, 4'h3, 4'h1, 32'h00000011);
    chk("merge error", 32'h1, 32'(werr));
    dread(8'h01, 16'h0006, 16'habce, ecc(16'habcd));
    $display("end of test: double errors");
    dbg(8'h03, 16'h0006, 16'h5555, ecc(16'h5555));
    mem(1'b0, 4'h3, 4'hf, 32'h0);
    chk("debug written word", 32'h12345555, rdata);
    chk("invalid mark", 32'h0, 32'(inv));
    $display("end of test: debug commands");
    // Second reset: a debug read asked for during the fill waits, a second command is refused
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, sec_pkg::OFS_DBG_CMD, 32'h1);
    wb(1'b1, sec_pkg::OFS_DBG_CMD, 32'h2);
    wb(1'b0, sec_pkg::OFS_DBG_CMD, 32'h0);
    chk("busy command", 32'h1, q);
    do wb(1'b0, sec_pkg::OFS_DBG_CMD, 32'h0); while (q[1:0] !== 2'b00);
    wb(1'b0, sec_pkg::OFS_DBG_DATA, 32'h0);
    chk("raw data", 32'h0, q);
    wb(1'b0, sec_pkg::OFS_DBG_CHECK, 32'h0);
    chk("raw check", {26'h0, ecc(16'h0000)}, q);
    $display("end of test: reset and busy");
    print_verdict();
  end
endmodule
